// *** hw/instruction_fetch_frontend.sv ***
`timescale 1ns/100ps
module instruction_fetch_frontend (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// register bus
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// core context
	input  wire logic                        salvage_mode_strap,
	input  wire logic                        translation_on,
	// fetch requests
	input  wire logic                        fetch_valid,
	input  wire ifetch_pkg::fetch_req_t      fetch_req,
	output logic                             fetch_ready,
	// branch resolution and flush
	input  wire logic                        resolve_valid,
	input  wire ifetch_pkg::resolve_t        resolve,
	input  wire logic                        exception_flush,
	// second-level cache
	output logic                             l2_req_valid,
	output ifetch_pkg::l2_req_t              l2_req,
	input  wire logic                        l2_req_ready,
	input  wire logic                        l2_rsp_valid,
	input  wire logic [ifetch_pkg::LINE_W-1:0] l2_rsp_data,
	// decoder
	output logic                             dec_valid,
	output ifetch_pkg::fetch_out_t           dec
);

	typedef struct packed {
		ifetch_pkg::fetch_state_t                            st;
		logic                                                salvage;
		logic [ifetch_pkg::IDX_W-1:0]                        init_set;
		logic [2:0]                                          ctrl;
		logic [31:0]                                         prdata;
		logic [15:0]                                         perr_cnt;
		logic [15:0]                                         miss_cnt;
		ifetch_pkg::fetch_req_t                              pend;
		logic                                                alloc;
		logic                                                discard;
		logic                                                dec_valid;
		ifetch_pkg::fetch_out_t                              dec;
		ifetch_pkg::ras_snap_t                               ras;
		logic [ifetch_pkg::DIR_W-1:0]                        ghist;
		logic [ifetch_pkg::BTB_N-1:0]                        btb_v;
		logic [ifetch_pkg::DIR_N-1:0][1:0]                   dir;
	} ctl_t;

	// arrays are not reset: the sweep clears ic_v and plru, so salvage mode can skip it
	typedef struct packed {
		logic [ifetch_pkg::RAS_N-1:0][ifetch_pkg::VA_W-1:0]      ras_stk;
		logic [ifetch_pkg::BTB_N-1:0][ifetch_pkg::BTB_TAG_W-1:0] btb_tag;
		ifetch_pkg::br_kind_t [ifetch_pkg::BTB_N-1:0]            btb_kind;
		logic [ifetch_pkg::BTB_N-1:0][ifetch_pkg::VA_W-1:0]      btb_tgt;
		logic [ifetch_pkg::IND_N-1:0][ifetch_pkg::VA_W-1:0]      ind;
		logic [ifetch_pkg::SETS-1:0][ifetch_pkg::WAYS-1:0]       ic_v;
		logic [ifetch_pkg::SETS-1:0][ifetch_pkg::WAYS-1:0][ifetch_pkg::TAG_W-1:0] ic_tag;
		logic [ifetch_pkg::SETS-1:0][ifetch_pkg::WAYS-1:0]       ic_par;
		logic [ifetch_pkg::SETS-1:0][ifetch_pkg::WAYS-1:0][ifetch_pkg::LINE_W-1:0] ic_data;
		logic [ifetch_pkg::SETS-1:0][2:0]                        plru;
	} mem_t;

	typedef struct packed {
		ctl_t c;
		mem_t m;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic [1:0] plru_victim(input logic [2:0] t);
		plru_victim = t[0] ? {1'b1, t[2]} : {1'b0, t[1]};
	endfunction

	// tree bits point away from the way just used
	function automatic logic [2:0] plru_touch(input logic [2:0] t, input logic [1:0] w);
		logic [2:0] r;
		r = t;
		r[0] = ~w[1];
		if (w[1]) begin
			r[2] = ~w[0];
		end else begin
			r[1] = ~w[0];
		end
		plru_touch = r;
	endfunction

	function automatic logic [ifetch_pkg::DIR_W-1:0] dir_idx(
		input logic [ifetch_pkg::VA_W-1:0] pc, input logic [ifetch_pkg::DIR_W-1:0] h);
		dir_idx = pc[ifetch_pkg::DIR_W+1:2] ^ h;
	endfunction

	function automatic logic [ifetch_pkg::IND_W-1:0] ind_idx(
		input logic [ifetch_pkg::VA_W-1:0] pc, input logic [ifetch_pkg::DIR_W-1:0] h);
		ind_idx = pc[ifetch_pkg::IND_W+1:2] ^ h[ifetch_pkg::IND_W-1:0];
	endfunction

	function automatic logic [ifetch_pkg::BTB_IW-1:0] btb_idx(
		input logic [ifetch_pkg::VA_W-1:0] pc);
		btb_idx = pc[ifetch_pkg::BTB_IW+1:2];
	endfunction

	function automatic logic line_parity(
		input logic [ifetch_pkg::TAG_W-1:0] tag, input logic [ifetch_pkg::LINE_W-1:0] d);
		line_parity = ^{tag, d};
	endfunction

	function automatic logic is_call(input ifetch_pkg::br_kind_t k);
		is_call = (k == ifetch_pkg::BR_CALL) || (k == ifetch_pkg::BR_CALL_REG);
	endfunction

	// cache lookup against the physical address, so aliases cannot split a line
	logic [ifetch_pkg::IDX_W-1:0] req_set;
	logic [ifetch_pkg::TAG_W-1:0] req_tag;
	logic [ifetch_pkg::WAYS-1:0]  way_hit;
	logic                         hit;
	logic                         hit_perr;
	logic [1:0]                   hit_way;
	logic                         flush;

	assign req_set = fetch_req.paddr[ifetch_pkg::IDX_W+ifetch_pkg::OFF_W-1:ifetch_pkg::OFF_W];
	assign req_tag = fetch_req.paddr[ifetch_pkg::PA_W-1:ifetch_pkg::IDX_W+ifetch_pkg::OFF_W];
	assign flush   = exception_flush | (resolve_valid & resolve.mispredict);

	always_comb begin
		way_hit  = '0;
		hit_way  = 2'h0;
		hit_perr = 1'b0;
		for (int w = 0; w < ifetch_pkg::WAYS; w++) begin
			way_hit[w] = s_q.m.ic_v[req_set][w] && (s_q.m.ic_tag[req_set][w] == req_tag);
			if (way_hit[w]) begin
				hit_way  = 2'(w);
				hit_perr = line_parity(s_q.m.ic_tag[req_set][w], s_q.m.ic_data[req_set][w])
					!= s_q.m.ic_par[req_set][w];
			end
		end
	end
	assign hit = |way_hit;

	always_comb begin
		logic                          emit;
		logic [ifetch_pkg::VA_W-1:0]   epc;
		logic [ifetch_pkg::WORD_W-1:0] eword;
		logic [ifetch_pkg::LINE_W-1:0] eline;
		logic [ifetch_pkg::BTB_IW-1:0] bi;
		logic                          bhit;
		ifetch_pkg::pred_t             pr;
		logic [1:0]                    vw;
		logic [ifetch_pkg::IDX_W-1:0]  pset;
		logic [ifetch_pkg::TAG_W-1:0]  ptag;
		logic [ifetch_pkg::DIR_W-1:0]  di;
		logic                          acc;
		emit  = 1'b0;
		epc   = '0;
		eword = '0;
		eline = '0;
		bi    = '0;
		bhit  = 1'b0;
		pr    = '0;
		vw    = 2'h0;
		pset  = '0;
		ptag  = '0;
		di    = '0;
		acc   = 1'b0;
		s_d   = s_q;
		s_d.c.dec_valid = 1'b0;

		case (s_q.c.st)
		ifetch_pkg::ST_START: begin
			// strap sampled on the first edge after reset release
			s_d.c.salvage = salvage_mode_strap;
			s_d.c.st      = salvage_mode_strap ? ifetch_pkg::ST_IDLE : ifetch_pkg::ST_INIT;
		end
		ifetch_pkg::ST_INIT: begin
			s_d.m.ic_v[s_q.c.init_set] = '0;
			s_d.m.plru[s_q.c.init_set] = 3'h0;
			s_d.c.init_set = s_q.c.init_set + 1'b1;
			if (s_q.c.init_set == ifetch_pkg::IDX_W'(ifetch_pkg::SETS - 1)) begin
				s_d.c.st = ifetch_pkg::ST_IDLE;
			end
		end
		ifetch_pkg::ST_IDLE: begin
			if (fetch_valid) begin
				if (s_q.c.ctrl[ifetch_pkg::CTRL_ICACHE_BIT] && hit && !hit_perr) begin
					emit  = 1'b1;
					epc   = fetch_req.vaddr;
					eline = s_q.m.ic_data[req_set][hit_way];
					s_d.m.plru[req_set] = plru_touch(s_q.m.plru[req_set], hit_way);
				end else begin
					if (s_q.c.ctrl[ifetch_pkg::CTRL_ICACHE_BIT] && hit && hit_perr) begin
						// bad line dropped and refetched, never handed to decode
						s_d.m.ic_v[req_set][hit_way] = 1'b0;
						s_d.c.perr_cnt = s_q.c.perr_cnt + 16'h1;
					end
					s_d.c.pend     = fetch_req;
					s_d.c.alloc    = s_q.c.ctrl[ifetch_pkg::CTRL_ICACHE_BIT];
					s_d.c.discard  = 1'b0;
					s_d.c.miss_cnt = s_q.c.miss_cnt + 16'h1;
					s_d.c.st       = ifetch_pkg::ST_REQ;
				end
			end
		end
		ifetch_pkg::ST_REQ: begin
			if (l2_req_ready) begin
				s_d.c.st = ifetch_pkg::ST_WAIT;
			end
		end
		ifetch_pkg::ST_WAIT: begin
			if (l2_rsp_valid) begin
				pset = s_q.c.pend.paddr[ifetch_pkg::IDX_W+ifetch_pkg::OFF_W-1:ifetch_pkg::OFF_W];
				ptag = s_q.c.pend.paddr[ifetch_pkg::PA_W-1:ifetch_pkg::IDX_W+ifetch_pkg::OFF_W];
				if (s_q.c.alloc) begin
					// an invalid way is taken first, else the tree's victim
					vw = plru_victim(s_q.m.plru[pset]);
					for (int w = ifetch_pkg::WAYS - 1; w >= 0; w--) begin
						if (!s_q.m.ic_v[pset][w]) begin
							vw = 2'(w);
						end
					end
					s_d.m.ic_v[pset][vw]    = 1'b1;
					s_d.m.ic_tag[pset][vw]  = ptag;
					s_d.m.ic_data[pset][vw] = l2_rsp_data;
					s_d.m.ic_par[pset][vw]  = line_parity(ptag, l2_rsp_data);
					s_d.m.plru[pset]        = plru_touch(s_q.m.plru[pset], vw);
				end
				emit     = !s_q.c.discard;
				epc      = s_q.c.pend.vaddr;
				eline    = l2_rsp_data;
				s_d.c.st = ifetch_pkg::ST_IDLE;
			end
		end
		default: begin
			s_d.c.st = ifetch_pkg::ST_START;
		end
		endcase

		// a miss in flight keeps its fill but loses its decode slot
		if (flush && (s_q.c.st == ifetch_pkg::ST_REQ || s_q.c.st == ifetch_pkg::ST_WAIT)) begin
			s_d.c.discard = 1'b1;
		end

		// prediction for the word being handed to decode
		eword = eline[epc[ifetch_pkg::OFF_W-1:2]*ifetch_pkg::WORD_W +: ifetch_pkg::WORD_W];
		bi    = btb_idx(epc);
		bhit  = s_q.c.btb_v[bi] && (s_q.m.btb_tag[bi] == epc[ifetch_pkg::VA_W-1:ifetch_pkg::BTB_IW+2]);
		pr.snap = s_q.c.ras;
		pr.kind = s_q.m.btb_kind[bi];
		pr.valid = bhit && translation_on && s_q.c.ctrl[ifetch_pkg::CTRL_PRED_BIT];
		case (pr.kind)
		ifetch_pkg::BR_COND: begin
			pr.taken  = s_q.c.dir[dir_idx(epc, s_q.c.ghist)][1];
			pr.target = s_q.m.btb_tgt[bi];
		end
		ifetch_pkg::BR_UNCOND, ifetch_pkg::BR_CALL: begin
			pr.taken  = 1'b1;
			pr.target = s_q.m.btb_tgt[bi];
		end
		ifetch_pkg::BR_INDIRECT, ifetch_pkg::BR_CALL_REG: begin
			pr.taken  = 1'b1;
			pr.target = s_q.m.ind[ind_idx(epc, s_q.c.ghist)];
		end
		ifetch_pkg::BR_SUB_EXIT: begin
			pr.taken  = 1'b1;
			// empty stack falls back to the target cache entry
			pr.target = (s_q.c.ras.cnt != '0) ? s_q.m.ras_stk[s_q.c.ras.ptr]
				: s_q.m.btb_tgt[bi];
		end
		default: begin
			pr.valid = 1'b0;
		end
		endcase

		if (emit && !flush) begin
			s_d.c.dec_valid = 1'b1;
			s_d.c.dec.pc    = epc;
			s_d.c.dec.instr = eword;
			s_d.c.dec.pred  = pr;
			if (pr.valid && is_call(pr.kind)) begin
				// circular stack: a push past depth overwrites the oldest entry
				s_d.c.ras.ptr = s_q.c.ras.ptr + 1'b1;
				s_d.m.ras_stk[s_d.c.ras.ptr] = epc + ifetch_pkg::VA_W'(4);
				if (s_q.c.ras.cnt != (ifetch_pkg::RAS_W+1)'(ifetch_pkg::RAS_N)) begin
					s_d.c.ras.cnt = s_q.c.ras.cnt + 1'b1;
				end
			end else if (pr.valid && pr.kind == ifetch_pkg::BR_SUB_EXIT && s_q.c.ras.cnt != '0) begin
				s_d.c.ras.ptr = s_q.c.ras.ptr - 1'b1;
				s_d.c.ras.cnt = s_q.c.ras.cnt - 1'b1;
			end
		end

		// training from resolved branches
		if (resolve_valid && resolve.kind != ifetch_pkg::BR_NONE
			&& resolve.kind != ifetch_pkg::BR_NOPRED) begin
			bi = btb_idx(resolve.pc);
			if (resolve.taken || resolve.kind != ifetch_pkg::BR_COND) begin
				s_d.c.btb_v[bi]    = 1'b1;
				s_d.m.btb_tag[bi]  = resolve.pc[ifetch_pkg::VA_W-1:ifetch_pkg::BTB_IW+2];
				s_d.m.btb_kind[bi] = resolve.kind;
				s_d.m.btb_tgt[bi]  = resolve.target;
			end
			if (resolve.kind == ifetch_pkg::BR_COND) begin
				di = dir_idx(resolve.pc, s_q.c.ghist);
				if (resolve.taken && s_q.c.dir[di] != 2'h3) begin
					s_d.c.dir[di] = s_q.c.dir[di] + 2'h1;
				end else if (!resolve.taken && s_q.c.dir[di] != 2'h0) begin
					s_d.c.dir[di] = s_q.c.dir[di] - 2'h1;
				end
				s_d.c.ghist = {s_q.c.ghist[ifetch_pkg::DIR_W-2:0], resolve.taken};
			end
			if (resolve.kind == ifetch_pkg::BR_INDIRECT || resolve.kind == ifetch_pkg::BR_CALL_REG) begin
				s_d.m.ind[ind_idx(resolve.pc, s_q.c.ghist)] = resolve.target;
			end
		end

		// rewind the stack to the branch, then replay that branch's own effect
		if (resolve_valid && resolve.mispredict) begin
			s_d.c.ras = resolve.snap;
			if (is_call(resolve.kind)) begin
				s_d.c.ras.ptr = resolve.snap.ptr + 1'b1;
				s_d.m.ras_stk[s_d.c.ras.ptr] = resolve.pc + ifetch_pkg::VA_W'(4);
				if (resolve.snap.cnt != (ifetch_pkg::RAS_W+1)'(ifetch_pkg::RAS_N)) begin
					s_d.c.ras.cnt = resolve.snap.cnt + 1'b1;
				end
			end else if (resolve.kind == ifetch_pkg::BR_SUB_EXIT && resolve.snap.cnt != '0) begin
				s_d.c.ras.ptr = resolve.snap.ptr - 1'b1;
				s_d.c.ras.cnt = resolve.snap.cnt - 1'b1;
			end
		end

		// register bus: read data latched in setup, writes land in access
		acc = psel && penable;
		if (psel && !penable) begin
			case (paddr)
			ifetch_pkg::CTRL_OFF: s_d.c.prdata = {29'h0, s_q.c.ctrl};
			ifetch_pkg::STAT_OFF: begin
				s_d.c.prdata = 32'h0;
				s_d.c.prdata[ifetch_pkg::STAT_READY_BIT] = (s_q.c.st != ifetch_pkg::ST_START)
					&& (s_q.c.st != ifetch_pkg::ST_INIT);
				s_d.c.prdata[ifetch_pkg::STAT_SALVAGE_BIT] = s_q.c.salvage;
				s_d.c.prdata[ifetch_pkg::STAT_PRED_BIT] = translation_on
					&& s_q.c.ctrl[ifetch_pkg::CTRL_PRED_BIT];
				s_d.c.prdata[ifetch_pkg::STAT_RASCNT_LSB +: ifetch_pkg::RAS_W+1] = s_q.c.ras.cnt;
			end
			ifetch_pkg::PERR_OFF: s_d.c.prdata = {16'h0, s_q.c.perr_cnt};
			ifetch_pkg::MISS_OFF: s_d.c.prdata = {16'h0, s_q.c.miss_cnt};
			default: s_d.c.prdata = 32'h0;
			endcase
		end
		if (acc && pwrite) begin
			case (paddr)
			ifetch_pkg::CTRL_OFF: s_d.c.ctrl = pwdata[2:0];
			// a clear in the same cycle as an event keeps that event
			ifetch_pkg::PERR_OFF: s_d.c.perr_cnt = s_d.c.perr_cnt - s_q.c.perr_cnt;
			ifetch_pkg::MISS_OFF: s_d.c.miss_cnt = s_d.c.miss_cnt - s_q.c.miss_cnt;
			default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.c <= '{st: ifetch_pkg::ST_START, ctrl: ifetch_pkg::CTRL_RST,
				dir: {ifetch_pkg::DIR_N{ifetch_pkg::DIR_RST}}, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign fetch_ready  = (s_q.c.st == ifetch_pkg::ST_IDLE);
	assign l2_req_valid = (s_q.c.st == ifetch_pkg::ST_REQ);
	// device pages go out as plain non-cacheable reads
	assign l2_req.line_addr = {s_q.c.pend.paddr[ifetch_pkg::PA_W-1:ifetch_pkg::OFF_W],
		ifetch_pkg::OFF_W'(0)};
	assign l2_req.cacheable = s_q.c.pend.cacheable && !s_q.c.pend.device
		&& s_q.c.ctrl[ifetch_pkg::CTRL_ICACHE_BIT];
	assign l2_req.l2_lookup = s_q.c.ctrl[ifetch_pkg::CTRL_L2_BIT];
	assign dec_valid = s_q.c.dec_valid;
	assign dec       = s_q.c.dec;
	assign prdata    = s_q.c.prdata;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && (paddr != ifetch_pkg::CTRL_OFF)
		&& (paddr != ifetch_pkg::STAT_OFF) && (paddr != ifetch_pkg::PERR_OFF)
		&& (paddr != ifetch_pkg::MISS_OFF);

endmodule

// *** include/ifetch_pkg.sv ***
package ifetch_pkg;

	// address widths and cache geometry (32KB, 4 ways, 64-byte lines)
	localparam int VA_W      = 48;
	localparam int PA_W      = 40;
	localparam int WAYS      = 4;
	localparam int SETS      = 128;
	localparam int IDX_W     = 7;
	localparam int OFF_W     = 6;
	localparam int TAG_W     = PA_W - IDX_W - OFF_W;
	localparam int LINE_W    = 512;
	localparam int WORD_W    = 32;

	// predictor structures
	localparam int BTB_N     = 16;
	localparam int BTB_IW    = 4;
	localparam int BTB_TAG_W = VA_W - BTB_IW - 2;
	localparam int DIR_N     = 64;
	localparam int DIR_W     = 6;
	localparam int IND_N     = 16;
	localparam int IND_W     = 4;
	localparam int RAS_N     = 8;
	localparam int RAS_W     = 3;

	// register map
	localparam logic [11:0] CTRL_OFF  = 12'h000;
	localparam logic [11:0] STAT_OFF  = 12'h004;
	localparam logic [11:0] PERR_OFF  = 12'h008;
	localparam logic [11:0] MISS_OFF  = 12'h00c;
	localparam int CTRL_ICACHE_BIT    = 0;
	localparam int CTRL_L2_BIT        = 1;
	localparam int CTRL_PRED_BIT      = 2;
	localparam logic [2:0] CTRL_RST   = 3'h0;
	localparam int STAT_READY_BIT     = 0;
	localparam int STAT_SALVAGE_BIT   = 1;
	localparam int STAT_PRED_BIT      = 2;
	localparam int STAT_RASCNT_LSB    = 4;
	localparam logic [1:0] DIR_RST    = 2'h1;

	typedef enum logic [4:0] {
		ST_START = 5'h01,
		ST_INIT  = 5'h02,
		ST_IDLE  = 5'h04,
		ST_REQ   = 5'h08,
		ST_WAIT  = 5'h10
	} fetch_state_t;

	typedef enum logic [2:0] {
		BR_NONE     = 3'h0,
		BR_COND     = 3'h1,
		BR_UNCOND   = 3'h2,
		BR_INDIRECT = 3'h3,
		BR_CALL     = 3'h4,
		BR_CALL_REG = 3'h5,
		BR_SUB_EXIT = 3'h6,
		BR_NOPRED   = 3'h7
	} br_kind_t;

	typedef struct packed {
		logic [RAS_W-1:0] ptr;
		logic [RAS_W:0]   cnt;
	} ras_snap_t;

	typedef struct packed {
		logic [VA_W-1:0] vaddr;
		logic [PA_W-1:0] paddr;
		logic            cacheable;
		logic            device;
	} fetch_req_t;

	typedef struct packed {
		logic [PA_W-1:0] line_addr;
		logic            cacheable;
		logic            l2_lookup;
	} l2_req_t;

	typedef struct packed {
		logic            valid;
		logic            taken;
		logic [VA_W-1:0] target;
		br_kind_t        kind;
		ras_snap_t       snap;
	} pred_t;

	typedef struct packed {
		logic [VA_W-1:0]   pc;
		logic [WORD_W-1:0] instr;
		pred_t             pred;
	} fetch_out_t;

	typedef struct packed {
		logic [VA_W-1:0] pc;
		br_kind_t        kind;
		logic            taken;
		logic [VA_W-1:0] target;
		logic            mispredict;
		ras_snap_t       snap;
	} resolve_t;

endpackage

// *** tb/ifetch_checker.sv ***
`timescale 1ns/100ps
module ifetch_checker (
	// clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// register writes
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	// context and fetch
	input wire logic                   salvage_mode_strap,
	input wire logic                   translation_on,
	input wire logic                   fetch_valid,
	input wire ifetch_pkg::fetch_req_t fetch_req,
	input wire logic                   fetch_ready,
	input wire logic                   resolve_valid,
	input wire ifetch_pkg::resolve_t   resolve,
	input wire logic                   exception_flush,
	// second level and decoder
	input wire logic                   l2_req_valid,
	input wire ifetch_pkg::l2_req_t    l2_req,
	input wire logic                   l2_req_ready,
	input wire logic                   dec_valid,
	input wire ifetch_pkg::fetch_out_t dec
);
	logic [2:0]  ctrl_q;
	logic [39:0] pa_q;
	logic        nc_q;
	logic        pok_q;
	logic        fl_q;
	logic [7:0]  up_q;
	wire take = fetch_valid && fetch_ready;
	wire flush = exception_flush || (resolve_valid && resolve.mispredict);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 3'h0;
			pa_q <= 40'h0;
			nc_q <= 1'b0;
			pok_q <= 1'b0;
			fl_q <= 1'b0;
			up_q <= 8'h00;
		end else begin
			if (psel && penable && pwrite && paddr == ifetch_pkg::CTRL_OFF)
				ctrl_q <= pwdata[2:0];
			if (take) begin
				pa_q <= fetch_req.paddr;
				nc_q <= !fetch_req.cacheable || fetch_req.device;
				pok_q <= translation_on && ctrl_q[2];
			end
			// a flush while a miss is out lasts until the unit is idle again
			fl_q <= !fetch_ready && (fl_q || flush);
			if (up_q != 8'hff)
				up_q <= up_q + 8'h01;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a flush in the take cycle itself drops a hit, so only clean takes count
	sequence s_take;
		take && !flush ##1 1'b1;
	endsequence
	chk_take_answer: assert property (s_take |-> dec_valid || l2_req_valid)
		else $error("fetch got no answer");
	chk_l2_hold: assert property (l2_req_valid && !l2_req_ready |=> l2_req_valid && $stable(l2_req))
		else $error("line request dropped");
	chk_l2_cache: assert property (l2_req_valid |-> l2_req.cacheable == (ctrl_q[0] && !nc_q))
		else $error("wrong cacheability");
	chk_l2_lookup: assert property (l2_req_valid |-> l2_req.l2_lookup == ctrl_q[1])
		else $error("wrong lookup flag");
	chk_line_addr: assert property (l2_req_valid |-> l2_req.line_addr == {pa_q[39:6], 6'h00})
		else $error("wrong line address");
	chk_flush_drop: assert property (fl_q |-> !dec_valid)
		else $error("flushed fetch delivered");
	chk_pred_gate: assert property (dec_valid && dec.pred.valid |-> pok_q)
		else $error("prediction while off");
	chk_no_sys: assert property (dec_valid && dec.pred.valid |-> dec.pred.kind != ifetch_pkg::BR_NOPRED)
		else $error("system kind predicted");
	chk_init_sweep: assert property (fetch_ready && !salvage_mode_strap |-> up_q >= 8'h81)
		else $error("ready before sweep");
endmodule
bind instruction_fetch_frontend ifetch_checker i_chk (.*);

// *** tb/instruction_fetch_frontend_tb.sv ***
`timescale 1ns/100ps
module instruction_fetch_frontend_tb;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic salvage_mode_strap = 1'b0;
	logic translation_on, fetch_valid, fetch_ready, resolve_valid, exception_flush;
	logic l2_req_valid, l2_req_ready, l2_rsp_valid, dec_valid;
	logic [511:0] l2_rsp_data;
	logic [3:0] lat;
	ifetch_pkg::fetch_req_t fetch_req;
	ifetch_pkg::resolve_t resolve;
	ifetch_pkg::l2_req_t l2_req;
	ifetch_pkg::fetch_out_t dec;
	logic [128:0] exp_q[$];
	logic [128:0] got;
	logic [39:0] a, b, p0;
	logic [47:0] t;
	int err_count = 0;
	int tests_run = 0;
	always #20 pclk = ~pclk;
	instruction_fetch_frontend i_instruction_fetch_frontend (.*);
	l2_model i_l2_model (.*);
	task automatic report_and_stop;
		// a promised output that never came is a mismatch too
		err_count += exp_q.size();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic ck_dec(input logic [128:0] g, e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic ck_reg(input logic [32:0] g, e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wait_rdy;
		for (int n = 0; !fetch_ready; n++) begin
			if (n > 400) begin
				err_count++;
				report_and_stop;
			end
			@(posedge pclk);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
		output logic [32:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (int n = 0; !pready; n++) begin
			if (n > 40) begin
				err_count++;
				report_and_stop;
			end
			@(posedge pclk);
		end
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		logic [32:0] r;
		apb(1'b1, ad, d, r);
	endtask
	task automatic rd(input logic [11:0] ad, input logic [32:0] e);
		logic [32:0] r;
		apb(1'b0, ad, 32'h0, r);
		ck_reg(r, e);
	endtask
	// a flushed fetch notes no result; any output for it is a mismatch
	task automatic fetch(input logic [39:0] pa, input logic c, d, fl, pv, input logic [47:0] tg);
		fetch_req <= '{{8'h00, pa}, pa, c, d};
		fetch_valid <= 1'b1;
		lat <= 4'($urandom_range(9));
		@(posedge pclk);
		wait_rdy;
		fetch_valid <= 1'b0;
		if (!fl)
			exp_q.push_back({8'h00, pa, pa[31:2], 2'b10, pv, pv ? tg : 48'h0});
		else begin
			exception_flush <= 1'b1;
			@(posedge pclk);
			exception_flush <= 1'b0;
		end
		@(posedge pclk);
		wait_rdy;
	endtask
	task automatic train(input logic [47:0] pc, tg, input ifetch_pkg::br_kind_t k);
		resolve <= '{pc, k, 1'b1, tg, 1'b0, '0};
		resolve_valid <= 1'b1;
		@(posedge pclk);
		resolve_valid <= 1'b0;
	endtask
	task automatic do_reset;
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		wait_rdy;
	endtask
	function automatic logic [39:0] rnd();
		return {$urandom, 2'b00, 4'($urandom_range(15)), 2'b00};
	endfunction
	always @(posedge pclk) begin
		got = {dec.pc, dec.instr, dec.pred.valid, dec.pred.valid ? dec.pred.target : 48'h0};
		if (dec_valid)
			ck_dec(got, exp_q.size() > 0 ? exp_q.pop_front() : ~got);
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, lat} = '0;
		{translation_on, fetch_valid, resolve_valid, exception_flush} = '0;
		fetch_req = '0;
		resolve = '0;
		void'($urandom(43231));
		do_reset;
		rd(ifetch_pkg::CTRL_OFF, 33'h0);
		wr(ifetch_pkg::STAT_OFF, 32'hffffffff);
		rd(ifetch_pkg::STAT_OFF, 33'h1);
		rd(12'h010, 33'h100000000);
		wr(ifetch_pkg::CTRL_OFF, 32'h2);
		a = rnd();
		repeat (2) fetch(a, 1'b1, 1'b0, 1'b0, 1'b0, 48'h0);
		rd(ifetch_pkg::MISS_OFF, 33'h2);
		wr(ifetch_pkg::MISS_OFF, 32'h0);
		wr(ifetch_pkg::CTRL_OFF, 32'h3);
		a = rnd();
		repeat (2) fetch(a, 1'b0, 1'b0, 1'b0, 1'b0, 48'h0);
		a = rnd(); // device line still allocated, so its second fetch hits
		repeat (2) fetch(a, 1'b1, 1'b1, 1'b0, 1'b0, 48'h0);
		a = rnd();
		fetch(a, 1'b1, 1'b0, 1'b1, 1'b0, 48'h0);
		fetch(a, 1'b1, 1'b0, 1'b0, 1'b0, 48'h0);
		rd(ifetch_pkg::MISS_OFF, 33'h3);
		wr(ifetch_pkg::CTRL_OFF, 32'h7);
		translation_on <= 1'b1;
		rd(ifetch_pkg::STAT_OFF, 33'h5);
		for (int i = 1; i < 5; i++) begin
			a = rnd();
			t = {14'h0, $urandom, 2'b00};
			if (i == 1)
				p0 = a;
			fetch(a, 1'b1, 1'b0, 1'b0, 1'b0, 48'h0);
			train({8'h00, a}, t, i == 4 ? ifetch_pkg::BR_NOPRED : ifetch_pkg::br_kind_t'(i[2:0]));
			fetch(a, 1'b1, 1'b0, 1'b0, i != 4, t);
		end
		// a call pushes its return address, the exit then predicts it
		a = rnd();
		b = rnd();
		train({8'h00, a}, t, ifetch_pkg::BR_CALL);
		fetch(a, 1'b1, 1'b0, 1'b0, 1'b1, t);
		rd(ifetch_pkg::STAT_OFF, 33'h15);
		train({8'h00, b}, t, ifetch_pkg::BR_SUB_EXIT);
		fetch(b, 1'b1, 1'b0, 1'b0, 1'b1, {8'h00, a} + 48'h4);
		rd(ifetch_pkg::STAT_OFF, 33'h5);
		translation_on <= 1'b0;
		rd(ifetch_pkg::STAT_OFF, 33'h1);
		fetch(p0, 1'b1, 1'b0, 1'b0, 1'b0, 48'h0);
		do_reset;
		wr(ifetch_pkg::CTRL_OFF, 32'h3);
		fetch(p0, 1'b1, 1'b0, 1'b0, 1'b0, 48'h0);
		rd(ifetch_pkg::MISS_OFF, 33'h1);
		// salvage start: ready at once with no sweep, caches left off
		salvage_mode_strap <= 1'b1;
		do_reset;
		rd(ifetch_pkg::STAT_OFF, 33'h3);
		report_and_stop;
	end
endmodule

// *** tb/l2_model.sv ***
`timescale 1ns/100ps
module l2_model (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// request side
	input  wire logic                l2_req_valid,
	input  wire ifetch_pkg::l2_req_t l2_req,
	output logic                     l2_req_ready,
	// response side
	input  wire logic [3:0]          lat,
	output logic                     l2_rsp_valid,
	output logic [511:0]             l2_rsp_data
);
	logic [39:0] a_q;
	logic [4:0]  n_q;
	wire take = l2_req_valid && l2_req_ready;
	// stalls every other cycle so a held request is exercised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			l2_req_ready <= 1'b0;
			n_q <= 5'h00;
			a_q <= 40'h0;
		end else begin
			l2_req_ready <= !l2_req_ready && n_q == 5'h00 && !take;
			if (take) begin
				n_q <= {1'b0, lat} + 5'h01;
				a_q <= l2_req.line_addr;
			end else if (n_q != 5'h00)
				n_q <= n_q - 5'h01;
		end
	end
	assign l2_rsp_valid = n_q == 5'h01;
	// idle data inverted so a stale line never passes for a fresh one
	always_comb
		for (int w = 0; w < 16; w++)
			l2_rsp_data[w*32+:32] = {a_q[31:6], 4'(w), 2'b10} ^ {32{!l2_rsp_valid}};
endmodule
